/* File: shared/usm_consts.svh */
`ifndef USM_CONSTS_SVH
`define USM_CONSTS_SVH

// pad slots of the serial-port group
`define USM_PAD_TXD    0
`define USM_PAD_CTS    1
`define USM_PAD_RXD    2
`define USM_PAD_RTS    3
`define USM_PAD_SS     4
`define USM_PAD_SCK    5
`define USM_PAD_MISO   6
`define USM_PAD_MOSI   7
`define USM_PAD_PB12   8
`define USM_PAD_PB10   9
`define USM_PAD_COUNT  10

// port c bits carried by the first seven pads
`define USM_PORT_C_WIDTH 7

// reset value of every registered pad and core-side signal
`define USM_RST_LEVEL 1'b0

`endif

/* File: shared/usm_pkg.sv */
package usm_pkg;

  // function carried by one pad
  typedef enum logic [1:0] {
    usm_fn_normal,
    usm_fn_gpio,
    usm_fn_alt
  } usm_func_t;

endpackage

/* File: src/usm_pad_cell.sv */
`timescale 1ns/1ps
`include "usm_consts.svh"

module usm_pad_cell (
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  usm_pkg::usm_func_t sel,
  input  wire logic          norm_out,
  input  wire logic          norm_oe,
  input  wire logic          gpio_out,
  input  wire logic          gpio_oe,
  input  wire logic          alt_out,
  input  wire logic          alt_oe,
  input  wire logic          pad_in,
  output logic               pad_out,
  output logic               pad_oe,
  output logic               norm_in,
  output logic               gpio_in,
  output logic               alt_in
);
  import usm_pkg::*;

  logic next_pad_out;
  logic next_pad_oe;
  logic next_norm_in;
  logic next_gpio_in;
  logic next_alt_in;

  // one function owns the pad; the others see a low input
  always_comb begin
    next_pad_out = `USM_RST_LEVEL;
    next_pad_oe  = 1'b0;
    next_norm_in = 1'b0;
    next_gpio_in = 1'b0;
    next_alt_in  = 1'b0;
    unique case (sel)
      usm_fn_normal: begin
        next_pad_out = norm_out & norm_oe;
        next_pad_oe  = norm_oe;
        next_norm_in = pad_in & ~norm_oe;
      end
      usm_fn_gpio: begin
        next_pad_out = gpio_out & gpio_oe;
        next_pad_oe  = gpio_oe;
        next_gpio_in = pad_in & ~gpio_oe;
      end
      usm_fn_alt: begin
        next_pad_out = alt_out & alt_oe;
        next_pad_oe  = alt_oe;
        next_alt_in  = pad_in & ~alt_oe;
      end
      // illegal code: pad released, a safe idle
      default: next_pad_oe = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pad_out <= `USM_RST_LEVEL;
      pad_oe  <= 1'b0;
      norm_in <= `USM_RST_LEVEL;
      gpio_in <= `USM_RST_LEVEL;
      alt_in  <= `USM_RST_LEVEL;
    end else begin
      pad_out <= next_pad_out;
      pad_oe  <= next_pad_oe;
      norm_in <= next_norm_in;
      gpio_in <= next_gpio_in;
      alt_in  <= next_alt_in;
    end
  end

endmodule // usm_pad_cell

/* File: src/usm_pin_mux.sv */
`timescale 1ns/1ps
`include "usm_consts.svh"

// Contract
// - The first uart pad drives uart transmit in normal mode and port c bit 0 as gpio.
// - The clear-to-send pad is an output raised only while the receiver can take data.
// - The clear-to-send pad is port c bit 1 as gpio and the spi rate control input as alt.
// - Ready-to-send is an input, seen by the core as uart_tx_permit; the txd pad is driven whether it is high or low.
// - The receive pad feeds uart receive, port c bit 2 as gpio, and timer 0 input as alt.
// - The ready-to-send pad is port c bit 3 as gpio and timer 1 input as alt.
// - The slave-select pad is an output as spi master and an input as spi slave.
// - The slave-select pad is port c bit 4 as gpio and carries a half-rate copy of the core clock as alt.
// - The spi clock pad drives the clock as master and takes it in as slave.
// - The spi clock pad is port c bit 5 as gpio and the show-cycle strobe as alt.
// - The miso pad is receive data as master and transmit data as slave.
// - The miso pad is port c bit 6 as gpio and the bus abort output as alt.
// - The mosi pad is transmit data as master and receive data as slave.
// - A port b pad carries uart transmit as its alt function.
// - The port b bit 12 pad is gpio bit 12 as gpio and uart receive as alt.
// - The port b uart transmit pad is gpio port b bit 10 as gpio.
module usm_pin_mux (
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  input  usm_pkg::usm_func_t                pad_func [`USM_PAD_COUNT],
  input  wire logic [`USM_PAD_COUNT-1:0]    pad_in,
  output logic      [`USM_PAD_COUNT-1:0]    pad_out,
  output logic      [`USM_PAD_COUNT-1:0]    pad_oe,
  input  wire logic [`USM_PORT_C_WIDTH-1:0] port_c_out,
  input  wire logic [`USM_PORT_C_WIDTH-1:0] port_c_oe,
  output logic      [`USM_PORT_C_WIDTH-1:0] port_c_in,
  input  wire logic                         port_b_bit10_out,
  input  wire logic                         port_b_bit10_oe,
  output logic                              port_b_bit10_in,
  input  wire logic                         port_b_bit12_out,
  input  wire logic                         port_b_bit12_oe,
  output logic                              port_b_bit12_in,
  input  wire logic                         uart_tx_data,
  input  wire logic                         uart_rx_ready,
  output logic                              uart_rx_data,
  output logic                              uart_tx_permit,
  input  wire logic                         spi_master,
  input  wire logic                         spi_ss_out,
  input  wire logic                         spi_sck_out,
  input  wire logic                         spi_tx_data,
  output logic                              spi_ss_in,
  output logic                              spi_sck_in,
  output logic                              spi_rx_data,
  output logic                              spi_rate_control_in,
  output logic                              timer_zero_input,
  output logic                              timer_one_input,
  output logic                              ref_clock_in,
  input  wire logic                         show_cycle_strobe,
  input  wire logic                         bus_abort
);
  import usm_pkg::*;

  logic [`USM_PAD_COUNT-1:0]    norm_out;
  logic [`USM_PAD_COUNT-1:0]    norm_oe;
  logic [`USM_PAD_COUNT-1:0]    gpio_out;
  logic [`USM_PAD_COUNT-1:0]    gpio_oe;
  logic [`USM_PAD_COUNT-1:0]    alt_out;
  logic [`USM_PAD_COUNT-1:0]    alt_oe;
  logic [`USM_PAD_COUNT-1:0]    norm_in;
  logic [`USM_PAD_COUNT-1:0]    gpio_in;
  logic [`USM_PAD_COUNT-1:0]    alt_in;
  logic                         platform_clock_out;
  logic                         next_platform_clock_out;
  logic                         next_uart_rx_data;
  logic                         next_uart_tx_permit;
  logic                         next_spi_ss_in;
  logic                         next_spi_sck_in;
  logic                         next_spi_rx_data;

  // per-pad sources and directions for each function
  always_comb begin
    norm_out = '0;
    norm_oe  = '0;
    alt_out  = '0;
    alt_oe   = '0;
    gpio_out = {port_b_bit10_out, port_b_bit12_out, 1'b0, port_c_out};
    gpio_oe  = {port_b_bit10_oe, port_b_bit12_oe, 1'b0, port_c_oe};
    norm_out[`USM_PAD_TXD]  = uart_tx_data;
    norm_oe[`USM_PAD_TXD]   = 1'b1;
    norm_out[`USM_PAD_CTS]  = uart_rx_ready;
    norm_oe[`USM_PAD_CTS]   = 1'b1;
    norm_out[`USM_PAD_SS]   = spi_ss_out;
    norm_oe[`USM_PAD_SS]    = spi_master;
    norm_out[`USM_PAD_SCK]  = spi_sck_out;
    norm_oe[`USM_PAD_SCK]   = spi_master;
    norm_out[`USM_PAD_MISO] = spi_tx_data;
    norm_oe[`USM_PAD_MISO]  = ~spi_master;
    norm_out[`USM_PAD_MOSI] = spi_tx_data;
    norm_oe[`USM_PAD_MOSI]  = spi_master;
    alt_out[`USM_PAD_SS]    = platform_clock_out;
    alt_oe[`USM_PAD_SS]     = 1'b1;
    alt_out[`USM_PAD_SCK]   = show_cycle_strobe;
    alt_oe[`USM_PAD_SCK]    = 1'b1;
    alt_out[`USM_PAD_MISO]  = bus_abort;
    alt_oe[`USM_PAD_MISO]   = 1'b1;
    alt_out[`USM_PAD_PB10]  = uart_tx_data;
    alt_oe[`USM_PAD_PB10]   = 1'b1;
  end

  genvar i;
  generate
    for (i = 0; i < `USM_PAD_COUNT; i++) begin : g_pad
      usm_pad_cell u_cell (
        .core_clk (core_clk),
        .reset    (reset),
        .sel      (pad_func[i]),
        .norm_out (norm_out[i]),
        .norm_oe  (norm_oe[i]),
        .gpio_out (gpio_out[i]),
        .gpio_oe  (gpio_oe[i]),
        .alt_out  (alt_out[i]),
        .alt_oe   (alt_oe[i]),
        .pad_in   (pad_in[i]),
        .pad_out  (pad_out[i]),
        .pad_oe   (pad_oe[i]),
        .norm_in  (norm_in[i]),
        .gpio_in  (gpio_in[i]),
        .alt_in   (alt_in[i])
      );
    end
  endgenerate

  // gpio and alt inputs come straight from the pad cell flops
  assign port_c_in           = gpio_in[`USM_PORT_C_WIDTH-1:0];
  assign port_b_bit12_in     = gpio_in[`USM_PAD_PB12];
  assign port_b_bit10_in     = gpio_in[`USM_PAD_PB10];
  assign spi_rate_control_in = alt_in[`USM_PAD_CTS];
  assign timer_zero_input    = alt_in[`USM_PAD_RXD];
  assign timer_one_input     = alt_in[`USM_PAD_RTS];
  assign ref_clock_in        = alt_in[`USM_PAD_MOSI];

  // flops cannot pass the clock itself; the pad shows a half-rate copy
  always_comb begin
    next_platform_clock_out = ~platform_clock_out;
    // unselected routes are low, so an or merges the two uart receive paths
    next_uart_rx_data   = norm_in[`USM_PAD_RXD] | alt_in[`USM_PAD_PB12];
    next_uart_tx_permit = norm_in[`USM_PAD_RTS];
    next_spi_ss_in      = norm_in[`USM_PAD_SS] & ~spi_master;
    next_spi_sck_in     = norm_in[`USM_PAD_SCK] & ~spi_master;
    next_spi_rx_data    = spi_master ? norm_in[`USM_PAD_MISO]
                                     : norm_in[`USM_PAD_MOSI];
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      platform_clock_out <= `USM_RST_LEVEL;
      uart_rx_data       <= `USM_RST_LEVEL;
      uart_tx_permit     <= `USM_RST_LEVEL;
      spi_ss_in          <= `USM_RST_LEVEL;
      spi_sck_in         <= `USM_RST_LEVEL;
      spi_rx_data        <= `USM_RST_LEVEL;
    end else begin
      platform_clock_out <= next_platform_clock_out;
      uart_rx_data       <= next_uart_rx_data;
      uart_tx_permit     <= next_uart_tx_permit;
      spi_ss_in          <= next_spi_ss_in;
      spi_sck_in         <= next_spi_sck_in;
      spi_rx_data        <= next_spi_rx_data;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_txd_normal_drive: assert property (
    pad_func[`USM_PAD_TXD] == usm_fn_normal |=>
      pad_oe[`USM_PAD_TXD] && pad_out[`USM_PAD_TXD] == $past(uart_tx_data))
    else $error("txd pad does not follow uart transmit");

  chk_cts_ready_out: assert property (
    pad_func[`USM_PAD_CTS] == usm_fn_normal |=>
      pad_oe[`USM_PAD_CTS] && pad_out[`USM_PAD_CTS] == $past(uart_rx_ready))
    else $error("cts pad does not show receiver ready");

  chk_tx_permit_rts: assert property (
    !uart_tx_permit ##1 $past(pad_func[`USM_PAD_RTS] != usm_fn_normal, 2) |->
      !uart_tx_permit)
    else $error("transmit permitted with rts pad not in normal mode");

  chk_ss_master_dir: assert property (
    pad_func[`USM_PAD_SS] == usm_fn_normal |=> pad_oe[`USM_PAD_SS] == $past(spi_master))
    else $error("slave-select direction wrong for spi mode");

  chk_sck_slave_in: assert property (
    pad_func[`USM_PAD_SCK] == usm_fn_normal && !spi_master ##1 !spi_master |=>
      spi_sck_in == $past(pad_in[`USM_PAD_SCK], 2))
    else $error("slave spi clock not taken from pad");

  chk_miso_slave_out: assert property (
    pad_func[`USM_PAD_MISO] == usm_fn_normal && !spi_master |=>
      pad_oe[`USM_PAD_MISO] && pad_out[`USM_PAD_MISO] == $past(spi_tx_data))
    else $error("slave miso pad not driving transmit data");

  chk_abort_alt_out: assert property (
    pad_func[`USM_PAD_MISO] == usm_fn_alt |=>
      pad_oe[`USM_PAD_MISO] && pad_out[`USM_PAD_MISO] == $past(bus_abort))
    else $error("abort not on miso pad in alt function");

  chk_pb10_alt_tx: assert property (
    pad_func[`USM_PAD_PB10] == usm_fn_alt |=>
      pad_oe[`USM_PAD_PB10] && pad_out[`USM_PAD_PB10] == $past(uart_tx_data))
    else $error("port b pad not carrying uart transmit");

  chk_timer0_gated: assert property (
    pad_func[`USM_PAD_RXD] != usm_fn_alt |=> !timer_zero_input)
    else $error("timer 0 input live while pad not in alt function");

  chk_port_c_bit0_in: assert property (
    pad_func[`USM_PAD_TXD] == usm_fn_gpio && !port_c_oe[0] |=>
      port_c_in[0] == $past(pad_in[`USM_PAD_TXD]))
    else $error("port c bit 0 not read from txd pad");

  cov_uart_normal: cover property (
    pad_func[`USM_PAD_RTS] == usm_fn_normal && pad_in[`USM_PAD_RTS] ##2 uart_tx_permit);
  cov_spi_slave: cover property (!spi_master && pad_func[`USM_PAD_MOSI] == usm_fn_normal);
  cov_pb12_rx: cover property (pad_func[`USM_PAD_PB12] == usm_fn_alt ##2 uart_rx_data);
  cov_clock_alt: cover property (pad_func[`USM_PAD_SS] == usm_fn_alt ##2 pad_out[`USM_PAD_SS]);

endmodule // usm_pin_mux

/* File: verif/usm_pad_partner.sv */
`timescale 1ns/1ps
`include "usm_consts.svh"

// far-side pads: drives a pad only while the chip has released it
module usm_pad_partner (
  input  wire logic                      core_clk,
  input  wire logic [`USM_PAD_COUNT-1:0] pad_out,
  input  wire logic [`USM_PAD_COUNT-1:0] pad_oe,
  input  wire logic [`USM_PAD_COUNT-1:0] ext_val,
  input  wire logic [`USM_PAD_COUNT-1:0] ext_oe,
  output logic      [`USM_PAD_COUNT-1:0] pad_in
);
  logic [`USM_PAD_COUNT-1:0] last = '0;

  // no pull on these pads: a floating one shows a changing level, never a stale one
  always @(posedge core_clk) begin
    last <= pad_in;
  end

  always_comb begin
    for (int i = 0; i < `USM_PAD_COUNT; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_oe[i]) begin
        pad_in[i] = ext_val[i];
      end else begin
        pad_in[i] = ~last[i];
      end
    end
  end
endmodule // usm_pad_partner

/* File: verif/usm_pin_mux_tb.sv */
`timescale 1ns/1ps
`include "usm_consts.svh"

`define CHK(name, exp, got) begin checked++; if ((got) !== (exp)) begin err_total++; \
  $display("FAIL %s exp %h got %h", name, exp, got); end end

module usm_pin_mux_tb;
  import usm_pkg::*;
  logic                         core_clk = 1'b0;
  logic                         reset;
  usm_func_t                    pad_func [`USM_PAD_COUNT];
  logic [`USM_PAD_COUNT-1:0]    pad_in, pad_out, pad_oe, ext_val, ext_oe;
  logic [`USM_PORT_C_WIDTH-1:0] port_c_out, port_c_oe, port_c_in;
  logic b10_out, b10_oe, b10_in, b12_out, b12_oe, b12_in;
  logic tx_data, rx_ready, rx_data, tx_permit, master, ss_out, sck_out, spi_tx;
  logic ss_in, sck_in, spi_rx, rate_in, tim0, tim1, ref_in, strobe, abort_out, v;
  int   err_total = 0;
  int   checked = 0;
  int   cycles = 0;

  usm_pin_mux i_usm_pin_mux (.core_clk(core_clk), .reset(reset), .pad_func(pad_func),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .port_c_out(port_c_out),
    .port_c_oe(port_c_oe), .port_c_in(port_c_in), .port_b_bit10_out(b10_out),
    .port_b_bit10_oe(b10_oe), .port_b_bit10_in(b10_in), .port_b_bit12_out(b12_out),
    .port_b_bit12_oe(b12_oe), .port_b_bit12_in(b12_in), .uart_tx_data(tx_data),
    .uart_rx_ready(rx_ready), .uart_rx_data(rx_data), .uart_tx_permit(tx_permit),
    .spi_master(master), .spi_ss_out(ss_out), .spi_sck_out(sck_out),
    .spi_tx_data(spi_tx), .spi_ss_in(ss_in), .spi_sck_in(sck_in), .spi_rx_data(spi_rx),
    .spi_rate_control_in(rate_in), .timer_zero_input(tim0), .timer_one_input(tim1),
    .ref_clock_in(ref_in), .show_cycle_strobe(strobe), .bus_abort(abort_out));

  usm_pad_partner i_usm_pad_partner (.core_clk(core_clk), .pad_out(pad_out),
    .pad_oe(pad_oe), .ext_val(ext_val), .ext_oe(ext_oe), .pad_in(pad_in));

  always #5 core_clk = ~core_clk;

  task automatic set_all(input usm_func_t f);
    for (int i = 0; i < `USM_PAD_COUNT; i++) begin
      pad_func[i] = f;
    end
  endtask

  // core inputs lag the pad by at most two flops, so three cycles covers every path
  task automatic settle();
    repeat (3) @(negedge core_clk);
  endtask

  task automatic t_uart_normal();
    set_all(usm_fn_normal);
    master = 1'b1;
    ext_oe = 10'h00c;
    ext_val = 10'h00c;
    tx_data = 1'b1;
    rx_ready = 1'b1;
    settle();
    `CHK("txd_pad", 2'b11, {pad_oe[0], pad_out[0]})
    `CHK("cts_pad", 2'b11, {pad_oe[1], pad_out[1]})
    `CHK("uart_rx_data", 1'b1, rx_data)
    `CHK("uart_tx_permit", 1'b1, tx_permit)
    `CHK("port_c_in", 7'h00, port_c_in)
    `CHK("timer_zero_input", 1'b0, tim0)
    rx_ready = 1'b0;
    tx_data = 1'b0;
    ext_val = 10'h004;
    settle();
    `CHK("cts_txd_low", 2'b00, pad_out[1:0])
    `CHK("uart_tx_permit", 1'b0, tx_permit)
  endtask

  task automatic t_spi(input logic m);
    set_all(usm_fn_normal);
    master = m;
    ss_out = 1'b1;
    sck_out = 1'b1;
    spi_tx = 1'b1;
    ext_oe = 10'h0f0;
    ext_val = 10'h0f0;
    settle();
    `CHK("spi_pad_oe", (m ? 4'hb : 4'h4), pad_oe[7:4])
    `CHK("spi_pad_out", (m ? 4'hb : 4'h4), pad_out[7:4])
    `CHK("spi_ss_in", ~m, ss_in)
    `CHK("spi_sck_in", ~m, sck_in)
    `CHK("spi_rx_data", 1'b1, spi_rx)
  endtask

  task automatic t_gpio();
    set_all(usm_fn_gpio);
    ext_oe = 10'h12a;
    ext_val = '1;
    port_c_out = 7'h7f;
    port_c_oe = 7'h55;
    b10_oe = 1'b1;
    b10_out = 1'b1;
    b12_oe = 1'b0;
    settle();
    `CHK("gpio_oe", 7'h55, pad_oe[6:0])
    `CHK("gpio_out", 7'h55, pad_out[6:0])
    `CHK("port_c_in", 7'h2a, port_c_in)
    `CHK("port_b_bit10_pad", 2'b11, {pad_oe[9], pad_out[9]})
    `CHK("port_b_bit12_in", 1'b1, b12_in)
    `CHK("uart_rx_data", 1'b0, rx_data)
    port_c_oe = 7'h2a;
    b10_oe = 1'b0;
    ext_oe = 10'h255;
    settle();
    `CHK("port_c_in", 7'h55, port_c_in)
    `CHK("port_b_bit10_in", 1'b1, b10_in)
    `CHK("gpio_out", 7'h2a, pad_out[6:0])
  endtask

  task automatic t_alt();
    set_all(usm_fn_alt);
    ext_oe = 10'h18e;
    ext_val = '1;
    strobe = 1'b1;
    abort_out = 1'b1;
    tx_data = 1'b1;
    settle();
    `CHK("spi_rate_control_in", 1'b1, rate_in)
    `CHK("timer_zero_input", 1'b1, tim0)
    `CHK("timer_one_input", 1'b1, tim1)
    `CHK("ref_clock_in", 1'b1, ref_in)
    `CHK("uart_rx_data", 1'b1, rx_data)
    `CHK("strobe_abort", 4'hf, {pad_oe[6:5], pad_out[6:5]})
    `CHK("alt_txd", 2'b11, {pad_oe[9], pad_out[9]})
    `CHK("clk_pad_oe", 1'b1, pad_oe[4])
    v = pad_out[4];
    @(negedge core_clk);
    `CHK("clk_toggle", 1'b1, v !== pad_out[4])
    strobe = 1'b0;
    abort_out = 1'b0;
    settle();
    `CHK("strobe_abort", 2'b00, pad_out[6:5])
  endtask

  task automatic t_illegal();
    set_all(usm_func_t'(2'b11));
    settle();
    `CHK("pad_oe", 10'h000, pad_oe)
    `CHK("uart_rx_data", 1'b0, rx_data)
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // the whole run needs under a hundred cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 500) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    reset = 1'b1;
    set_all(usm_fn_normal);
    {ext_val, ext_oe, port_c_out, port_c_oe} = '0;
    {b10_out, b10_oe, b12_out, b12_oe, tx_data, rx_ready, master} = '0;
    {ss_out, sck_out, spi_tx, strobe, abort_out} = '0;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    t_uart_normal();
    t_spi(1'b1);
    t_spi(1'b0);
    t_gpio();
    t_alt();
    t_illegal();
    tally_and_finish();
  end
endmodule // usm_pin_mux_tb
